// File: clkgen_regs.sv
// Purpose: serial slave register bank of a multi-output clock generator
// Assumes: scl, sda, power-good and straps are async pins; core clock oversamples scl
// Notes: sda output enable is active low; scl, sda and power-good levels pass two flops before use, straps are captured directly
`timescale 1ns/1ps
module clkgen_regs
    import clkgen_regs_pkg::*;
#(
    parameter logic [3:0] REVISION_ID = 4'h3,  // arbitrary value
    parameter logic [3:0] MAKER_ID = 4'h5      // arbitrary value
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_oe_n_out,
    input wire logic power_good_powerdown_pin_in,
    input wire logic strap_freq_select_hi_in,
    input wire logic strap_freq_select_lo_in,
    input wire logic strap_config_b_in,
    input wire logic strap_config_a_in,
    input wire logic strap_spread_en_in,
    input wire logic [3:0] vdd_detect_in,
    output regs_t regs_out,
    output strap_t strap_out
);
    state_t s_reg, s_next;

    // read mux: reserved bits read fixed values
    function automatic logic [7:0] rd_byte(input state_t s, input logic [3:0] i);
        logic [7:0] v;
        v = 8'h00;
        case (i)
            IDX_STRAP: v = {s.strap.freq_sel, s.strap.config_sel, s.r.strap_reg[3:0]};
            IDX_PD_RUN: v = s.r.pd_run_reg;
            IDX_SE_OE: v = s.r.se_oe_reg;
            IDX_DIFF_OE: v = s.r.diff_oe_reg;
            IDX_SPREAD: v = s.r.spread_reg | SPREAD_RSVD;
            IDX_V_OVR: v = s.r.v_ovr_reg;
            IDX_V_DET: v = V_DET_RSVD | {4'h0, s.strap.v_detect};
            IDX_REV_ID: v = {REVISION_ID, MAKER_ID};
            IDX_COUNT: v = s.r.count_reg;
            IDX_SE_SLEW: v = s.r.se_slew_reg;
            IDX_MIX_SLEW: v = s.r.mix_slew_reg;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    function automatic regs_t reg_defaults(input logic spread_strap);
        regs_t d;
        d.strap_reg = STRAP_RST;
        d.pd_run_reg = PD_RUN_RST;
        d.se_oe_reg = SE_OE_RST;
        d.diff_oe_reg = DIFF_OE_RST;
        d.spread_reg = {7'h00, spread_strap};
        d.v_ovr_reg = V_OVR_RST;
        d.count_reg = COUNT_RST;
        d.se_slew_reg = SE_SLEW_RST;
        d.mix_slew_reg = MIX_SLEW_RST;
        return d;
    endfunction

    logic scl_rise, scl_fall, start_cond, stop_cond, scl_v, sda_v;
    logic [7:0] rx_byte;
    always_comb begin
        scl_v = s_reg.scl_s[1];
        sda_v = s_reg.sda_s[1];
        scl_rise = s_reg.scl_s[1] & ~s_reg.scl_s[2];
        scl_fall = ~s_reg.scl_s[1] & s_reg.scl_s[2];
        start_cond = scl_v & s_reg.scl_s[2] & ~sda_v & s_reg.sda_s[2];
        stop_cond = scl_v & s_reg.scl_s[2] & sda_v & ~s_reg.sda_s[2];
        rx_byte = {s_reg.shift[6:0], sda_v};
    end

    // next-state logic: synchronisers, strap latch, serial engine, register writes
    always_comb begin
        logic pd_edge;
        logic [7:0] wv;
        pd_edge = 1'b0;
        wv = 8'h00;
        s_next = s_reg;
        // second-stage samples feed history bit [2]; bit [0] read only by [1]
        s_next.scl_s = {s_reg.scl_s[1:0], scl_in};
        s_next.sda_s = {s_reg.sda_s[1:0], sda_in};
        s_next.pg_s = {s_reg.pg_s[0], power_good_powerdown_pin_in};
        s_next.pg_prev = s_reg.pg_s[1];
        pd_edge = s_reg.pg_prev & ~s_reg.pg_s[1];
        // cold start on power-down when configured
        if (pd_edge && !s_reg.r.strap_reg[STRAP_COLD_BIT]) begin
            s_next.r = reg_defaults(1'b0);
            s_next.latched = 1'b0;
        end
        // strap capture on first power-good assertion after reset or a cold start
        if (s_reg.pg_s[1] && !s_reg.latched) begin
            s_next.latched = 1'b1;
            s_next.strap.freq_sel = {strap_freq_select_hi_in, strap_freq_select_lo_in};
            s_next.strap.config_sel = {strap_config_b_in, strap_config_a_in};
            s_next.strap.spread_en = strap_spread_en_in;
            s_next.strap.v_detect = vdd_detect_in;
            s_next.r.spread_reg[0] = strap_spread_en_in;
        end
        if (start_cond) begin
            s_next.st = ST_ADDR;
            s_next.bit_cnt = 3'd0;
            // clear stale byte so the scl fall after start is not taken as an address
            s_next.shift = 8'h00;
            s_next.sda_oe_n = 1'b1;
        end else if (stop_cond) begin
            s_next.st = ST_IDLE;
            s_next.sda_oe_n = 1'b1;
        end else begin
            case (s_reg.st)
                ST_IDLE: s_next.sda_oe_n = 1'b1;
                ST_ADDR, ST_RX: begin
                    if (scl_rise) begin
                        s_next.shift = rx_byte;
                        s_next.bit_cnt = s_reg.bit_cnt + 3'd1;
                    end
                    if (scl_fall && s_reg.bit_cnt == 3'd0 && s_reg.shift != 8'h00
                            && s_reg.st == ST_ADDR) begin
                        if (s_reg.shift[7:1] == DEV_ADDR) begin
                            s_next.sda_oe_n = 1'b0;
                            s_next.rd = s_reg.shift[0];
                            s_next.st = ST_RX_ACK;
                            if (s_reg.shift[0]) begin
                                s_next.ph = PH_COUNT;
                                s_next.remain = s_reg.r.count_reg[4:0];
                            end else begin
                                s_next.ph = PH_INDEX;
                            end
                        end else begin
                            s_next.st = ST_SKIP;
                        end
                    end else if (scl_fall && s_reg.bit_cnt == 3'd0 && s_reg.st == ST_RX) begin
                        s_next.sda_oe_n = 1'b0;
                        s_next.st = ST_RX_ACK;
                        case (s_reg.ph)
                            PH_INDEX: begin
                                s_next.index = s_reg.shift[3:0];
                                s_next.ph = PH_COUNT;
                            end
                            PH_COUNT: s_next.ph = PH_DATA;
                            default: begin
                                wv = s_reg.shift;
                                case (s_reg.index)
                                    IDX_STRAP: s_next.r.strap_reg = wv & STRAP_WMASK;
                                    IDX_PD_RUN: s_next.r.pd_run_reg = wv;
                                    IDX_SE_OE: s_next.r.se_oe_reg = wv & SE_OE_WMASK;
                                    IDX_DIFF_OE: s_next.r.diff_oe_reg = wv & DIFF_OE_WMASK;
                                    IDX_SPREAD: s_next.r.spread_reg = wv & SPREAD_WMASK;
                                    IDX_V_OVR: s_next.r.v_ovr_reg = wv & V_OVR_WMASK;
                                    IDX_COUNT: s_next.r.count_reg = wv & COUNT_WMASK;
                                    IDX_SE_SLEW: s_next.r.se_slew_reg = wv;
                                    IDX_MIX_SLEW: s_next.r.mix_slew_reg = wv & MIX_SLEW_WMASK;
                                    default: ;
                                endcase
                                s_next.index = s_reg.index + 4'd1;
                            end
                        endcase
                    end
                end
                ST_RX_ACK: begin
                    // on the falling edge that ends the ack bit: release sda for a write, drive the first data bit for a read
                    if (scl_fall) begin
                        s_next.bit_cnt = 3'd0;
                        if (s_reg.rd) begin
                            s_next.st = ST_TX;
                            s_next.shift = {3'h0, s_reg.remain};
                            s_next.sda_oe_n = s_next.shift[7]; // msb of the count byte
                            s_next.bit_cnt = 3'd1;
                        end else begin
                            s_next.st = ST_RX;
                            s_next.sda_oe_n = 1'b1;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (s_reg.bit_cnt == 3'd0) begin
                            s_next.st = ST_TX_ACK;
                            s_next.sda_oe_n = 1'b1;
                        end else begin
                            s_next.sda_oe_n = s_reg.shift[7 - s_reg.bit_cnt];
                            s_next.bit_cnt = s_reg.bit_cnt + 3'd1;
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        if (sda_v || s_reg.remain == 5'd0) begin
                            s_next.st = ST_SKIP;
                        end else begin
                            s_next.shift = rd_byte(s_reg, s_reg.index);
                            s_next.index = s_reg.index + 4'd1;
                            s_next.remain = s_reg.remain - 5'd1;
                            s_next.ph = PH_DATA;
                        end
                    end else if (scl_fall) begin
                        s_next.st = ST_TX;
                        s_next.sda_oe_n = s_reg.shift[7];
                        s_next.bit_cnt = 3'd1;
                    end
                end
                ST_SKIP: s_next.sda_oe_n = 1'b1;
                default: s_next.st = ST_IDLE;
            endcase
        end
    end

    // state register
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_reg <= '{st: ST_IDLE, ph: PH_INDEX, rd: 1'b0, bit_cnt: 3'd0, shift: 8'h00,
                index: 4'h0, remain: 5'd0, sda_oe_n: 1'b1, scl_s: 3'b111, sda_s: 3'b111,
                pg_s: 2'b00, pg_prev: 1'b0, latched: 1'b0, strap: '0,
                r: '{strap_reg: STRAP_RST, pd_run_reg: PD_RUN_RST, se_oe_reg: SE_OE_RST,
                    diff_oe_reg: DIFF_OE_RST, spread_reg: 8'h00, v_ovr_reg: V_OVR_RST,
                    count_reg: COUNT_RST, se_slew_reg: SE_SLEW_RST,
                    mix_slew_reg: MIX_SLEW_RST}};
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from flops
    always_comb begin
        sda_oe_n_out = s_reg.sda_oe_n;
        regs_out = s_reg.r;
        strap_out = s_reg.strap;
    end

    // checks
    addr_ack_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (s_reg.st == ST_ADDR && s_next.st == ST_RX_ACK) |-> s_reg.shift[7:1] == DEV_ADDR)
        else $error("ack given to foreign address");
    reserved_bits_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (s_reg.r.se_oe_reg[5] == 1'b0) && (s_reg.r.diff_oe_reg[7:5] == 3'h0))
        else $error("reserved bit took a write");
    count_field_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        s_reg.r.count_reg[7:5] == 3'h0) else $error("count upper bits set");
    cold_start_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (s_reg.pg_prev && !s_reg.pg_s[1] && !s_reg.r.strap_reg[0])
        |=> (s_reg.r.pd_run_reg == PD_RUN_RST && !s_reg.latched))
        else $error("cold start did not restore defaults");
    strap_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (s_reg.latched && $past(s_reg.latched)) |-> $stable(s_reg.strap))
        else $error("strap copy changed while latched");
    ack_low_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (s_reg.st == ST_RX_ACK) |-> !s_reg.sda_oe_n) else $error("ack not driven");
    div_field_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        s_reg.r.strap_reg[1] == 1'b0) else $error("reserved divider neighbour set");
    tx_release_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (s_reg.st == ST_TX_ACK) |-> s_reg.sda_oe_n) else $error("host ack slot driven");
    write_seen_c: cover property (@(posedge core_clk_in) disable iff (rst_in)
        s_reg.st == ST_RX_ACK && s_reg.ph == PH_DATA);
    read_seen_c: cover property (@(posedge core_clk_in) disable iff (rst_in)
        s_reg.st == ST_TX_ACK && s_reg.ph == PH_DATA);
    latch_seen_c: cover property (@(posedge core_clk_in) disable iff (rst_in)
        $rose(s_reg.latched));
endmodule

// File: clkgen_regs_pkg.sv
// Purpose: constants and types for the clock generator serial register bank
// Assumes: 8-bit registers indexed 0..11 over a two-wire serial slave port
// Notes: reset values and field positions live here, except the strap-derived spread register reset
package clkgen_regs_pkg;
    localparam logic [6:0] DEV_ADDR = 7'h61;            // write form c2, read form c3
    localparam logic [3:0] IDX_STRAP = 4'h0;
    localparam logic [3:0] IDX_PD_RUN = 4'h1;
    localparam logic [3:0] IDX_SE_OE = 4'h2;
    localparam logic [3:0] IDX_DIFF_OE = 4'h3;
    localparam logic [3:0] IDX_SPREAD = 4'h4;
    localparam logic [3:0] IDX_V_OVR = 4'h5;
    localparam logic [3:0] IDX_V_DET = 4'h6;
    localparam logic [3:0] IDX_REV_ID = 4'h7;
    localparam logic [3:0] IDX_RSVD = 4'h8;
    localparam logic [3:0] IDX_COUNT = 4'h9;
    localparam logic [3:0] IDX_SE_SLEW = 4'ha;
    localparam logic [3:0] IDX_MIX_SLEW = 4'hb;
    localparam logic [3:0] IDX_LAST = 4'hb;
    // writable masks and reset values
    localparam logic [7:0] STRAP_WMASK = 8'h0d;
    localparam logic [7:0] STRAP_RST = 8'h01;
    localparam int STRAP_COLD_BIT = 0;
    localparam logic [7:0] PD_RUN_RST = 8'hff;
    localparam int POWERDOWN_KEEP_RUNNING_ENABLE_BIT = 7;
    localparam logic [7:0] SE_OE_WMASK = 8'hdf;
    localparam logic [7:0] SE_OE_RST = 8'hdf;
    localparam logic [7:0] DIFF_OE_WMASK = 8'h1f;
    localparam logic [7:0] DIFF_OE_RST = 8'h1f;
    localparam logic [7:0] SPREAD_WMASK = 8'h07;
    localparam logic [7:0] SPREAD_RSVD = 8'hf8;         // reserved bits read one
    localparam logic [7:0] V_OVR_WMASK = 8'h1f;
    localparam logic [7:0] V_OVR_RST = 8'h00;
    localparam logic [7:0] V_DET_RSVD = 8'h10;
    localparam logic [7:0] COUNT_WMASK = 8'h1f;
    localparam logic [7:0] COUNT_RST = 8'h0a;
    localparam logic [7:0] SE_SLEW_RST = 8'hff;
    localparam logic [7:0] MIX_SLEW_WMASK = 8'hcf;
    localparam logic [7:0] MIX_SLEW_RST = 8'hca;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_RX = 3'b010,
        ST_RX_ACK = 3'b011,
        ST_TX = 3'b100,
        ST_TX_ACK = 3'b101,
        ST_SKIP = 3'b110
    } link_state_t;

    typedef enum logic [1:0] {
        PH_INDEX = 2'b00,
        PH_COUNT = 2'b01,
        PH_DATA = 2'b10
    } phase_t;

    typedef struct packed {
        logic [1:0] freq_sel;   // hi, lo
        logic [1:0] config_sel; // b, a
        logic spread_en;
        logic [3:0] v_detect;
    } strap_t;

    typedef struct packed {
        logic [7:0] strap_reg;
        logic [7:0] pd_run_reg;
        logic [7:0] se_oe_reg;
        logic [7:0] diff_oe_reg;
        logic [7:0] spread_reg;
        logic [7:0] v_ovr_reg;
        logic [7:0] count_reg;
        logic [7:0] se_slew_reg;
        logic [7:0] mix_slew_reg;
    } regs_t;

    typedef struct packed {
        link_state_t st;
        phase_t ph;
        logic rd;              // current transfer is a read
        logic [2:0] bit_cnt;
        logic [7:0] shift;
        logic [3:0] index;
        logic [4:0] remain;
        logic sda_oe_n;
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic [1:0] pg_s;
        logic pg_prev;
        logic latched;
        strap_t strap;
        regs_t r;
    } state_t;
endpackage

// File: smbus_host_model.sv
// Purpose: serial bus host model issuing block writes and block reads
// Assumes: open-drain data line with pull-up; a quarter bit is 5 core cycles
// Notes: returns ack flags and read bytes; all checking stays in the bench
`timescale 1ns/1ps
module smbus_host_model
    import clkgen_regs_pkg::*;
(
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_oe_n_out
);
    // idle bus: both lines released
    initial begin
        scl_out = 1'b1;
        sda_oe_n_out = 1'b1;
    end
    // wait a quarter bit, then set both lines
    task step(input logic c, input logic d);
        repeat (5) @(posedge clk_in);
        scl_out <= c;
        sda_oe_n_out <= d;
    endtask
    // start or repeated start, leaves scl low
    task start();
        step(scl_out, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask
    task stop();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b1, 1'b1);
    endtask
    // one bit: data set while scl low, sampled in the middle of the high phase
    task bitx(input logic b, output logic r);
        step(1'b0, b);
        step(1'b1, b);
        step(1'b1, b);
        r = sda_in;
        step(1'b0, b);
    endtask
    // eight bits msb first, then the ack bit
    task xfer(input logic [7:0] d, input logic a_in, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r);
            q[i] = r;
        end
        bitx(a_in, r);
        ack = ~r;
    endtask
    // block write: address, index, count, data; gives up on a missing address ack
    task write_regs(input logic [7:0] addr, input logic [7:0] idx, input logic [7:0] n,
                    input logic [7:0] d [16], output logic ok);
        logic [7:0] q;
        logic a;
        start();
        xfer(addr, 1'b1, q, a);
        ok = a;
        if (a) begin
            xfer(idx, 1'b1, q, a);
            ok &= a;
            xfer(n, 1'b1, q, a);
            ok &= a;
            for (int i = 0; i < n; i++) begin
                xfer(d[i], 1'b1, q, a);
                ok &= a;
            end
        end
        stop();
    endtask
    // block read: q[0] is the count byte, q[1..n] the data; last byte nacked
    task read_regs(input logic [7:0] idx, input int n, output logic [7:0] q [16],
                   output logic ok);
        logic a;
        start();
        xfer({DEV_ADDR, 1'b0}, 1'b1, q[0], a);
        ok = a;
        xfer(idx, 1'b1, q[0], a);
        ok &= a;
        start();
        xfer({DEV_ADDR, 1'b1}, 1'b1, q[0], a);
        ok &= a;
        for (int i = 0; i <= n; i++) begin
            xfer(8'hff, (i == n), q[i], a);
        end
        stop();
    endtask
endmodule

// File: clkgen_regs_bench.sv
// Purpose: self-checking bench for the serial register bank
// Assumes: host model on the serial pins, straps driven by the bench
// Notes: rows hold write data beside expected readback for all twelve bytes
`timescale 1ns/1ps
module clkgen_regs_bench
    import clkgen_regs_pkg::*;
;
    typedef struct packed {logic [7:0] wr; logic [7:0] exp;} row_t;
    logic core_clk_in, rst_in, pg, fs_hi, fs_lo, cf_b, cf_a, ss_en, scl, host_oe_n, dut_oe_n;
    logic [3:0] vdet;
    logic ok;
    wire sda;
    regs_t regs;
    strap_t straps;
    int errors, cmp_count;
    logic [7:0] wd [16] = '{default: 8'h00};
    logic [7:0] rd [16];
    row_t rows [12] = '{'{8'hff, 8'h9d}, '{8'h5a, 8'h5a}, '{8'h00, 8'h00}, '{8'he0, 8'h00},
        '{8'h06, 8'hfe}, '{8'hff, 8'h1f}, '{8'h00, 8'h1a}, '{8'h00, 8'h35},
        '{8'hff, 8'h00}, '{8'hec, 8'h0c}, '{8'h1b, 8'h1b}, '{8'hff, 8'hcf}};
    // pull-up: a line released by both parties reads high
    assign sda = host_oe_n & dut_oe_n;
    clkgen_regs DUT (.core_clk_in(core_clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda),
        .sda_oe_n_out(dut_oe_n), .power_good_powerdown_pin_in(pg),
        .strap_freq_select_hi_in(fs_hi), .strap_freq_select_lo_in(fs_lo),
        .strap_config_b_in(cf_b), .strap_config_a_in(cf_a), .strap_spread_en_in(ss_en),
        .vdd_detect_in(vdet), .regs_out(regs), .strap_out(straps));
    smbus_host_model host (.clk_in(core_clk_in), .sda_in(sda), .scl_out(scl),
        .sda_oe_n_out(host_oe_n));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task finish_test();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // power-good low then high again
    task power_cycle();
        @(posedge core_clk_in);
        pg <= 1'b0;
        repeat (8) @(posedge core_clk_in);
        pg <= 1'b1;
        repeat (8) @(posedge core_clk_in);
    endtask
    // default read of ten bytes from index 0, count byte first
    task check_defaults(input logic [7:0] b0, input logic [7:0] b4, input logic [7:0] b6);
        logic [7:0] e [11];
        e = '{8'h0a, b0, 8'hff, 8'hdf, 8'h1f, b4, 8'h00, b6, 8'h35, 8'h00, 8'h0a};
        host.read_regs(8'h00, 10, rd, ok);
        check({7'h0, ok}, 8'h01);
        for (int i = 0; i < 11; i++) begin
            check(rd[i], e[i]);
        end
    endtask
    // core clock, 25 ns period
    initial begin
        core_clk_in = 1'b0;
        forever #12.5 core_clk_in = ~core_clk_in;
    end
    // watchdog against a hung transfer
    initial begin
        repeat (40000) @(posedge core_clk_in);
        errors++;
        finish_test();
    end
    // main sequence
    initial begin
        errors = 0;
        cmp_count = 0;
        rst_in = 1'b1;
        pg = 1'b0;
        {fs_hi, fs_lo, cf_b, cf_a, ss_en, vdet} = {4'b1001, 1'b1, 4'ha};
        repeat (2) @(posedge core_clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        pg <= 1'b1;
        repeat (8) @(posedge core_clk_in);
        check_defaults(8'h91, 8'hf9, 8'h1a);
        // rows: one back-to-back block write over the bank, then full readback
        for (int i = 0; i < 12; i++) begin
            wd[i] = rows[i].wr;
        end
        host.write_regs(8'hc2, 8'h00, 8'h0c, wd, ok);
        check({7'h0, ok}, 8'h01);
        host.read_regs(8'h00, 12, rd, ok);
        check(rd[0], 8'h0c);
        for (int i = 0; i < 12; i++) begin
            check(rd[i + 1], rows[i].exp);
        end
        // foreign address ignored; index past the bank acked without effect
        wd[0] = 8'h00;
        host.write_regs(8'hc4, 8'h01, 8'h01, wd, ok);
        check({7'h0, ok}, 8'h00);
        host.write_regs(8'hc2, 8'h0c, 8'h01, wd, ok);
        check({7'h0, ok}, 8'h01);
        check(regs.pd_run_reg, 8'h5a);
        // warm power-down keeps registers and the first strap capture
        {fs_hi, fs_lo, cf_b, cf_a, ss_en, vdet} <= {4'b0110, 1'b0, 4'h5};
        power_cycle();
        check(regs.se_slew_reg, 8'h1b);
        check({3'h0, straps.freq_sel, straps.config_sel, straps.spread_en}, 8'h13);
        check({4'h0, straps.v_detect}, 8'h0a);
        // cold start: clear the cold bit together with the run enable
        wd[0] = 8'h0c;
        wd[1] = 8'h7f;
        host.write_regs(8'hc2, 8'h00, 8'h02, wd, ok);
        check({7'h0, ok}, 8'h01);
        power_cycle();
        check_defaults(8'h61, 8'hf8, 8'h15);
        check(regs.se_slew_reg, 8'hff);
        check(regs.mix_slew_reg, 8'hca);
        finish_test();
    end
endmodule
